// ==== core/lsr_consts.svh ====
// offsets, field positions, reset values and counts of the status bank
`ifndef LSR_CONSTS_SVH
`define LSR_CONSTS_SVH
// register byte addresses (low 12 address bits)
`define LSR_OFS_LINK 12'h0F0
`define LSR_OFS_SLOT 12'h0F4
`define LSR_OFS_IRQ_STAT 12'h100
`define LSR_OFS_IRQ_MASK 12'h104
// link status fields, upper half of the word at 0F0
`define LSR_B_SPEED 16
`define LSR_B_WIDTH 20
`define LSR_B_TERR 26
`define LSR_B_TRAIN 27
`define LSR_B_SCLK 28
`define LSR_B_DLA 29
`define LSR_B_RSVD 30
`define LSR_SPEED_CODE 4'h1
`define LSR_WIDTH_RST 6'h01
// slot capability fields
`define LSR_B_ABP 0
`define LSR_B_PCP 1
`define LSR_B_AIP 3
// interrupt status and mask fields
`define LSR_B_IRQ_TERR 0
`define LSR_B_IRQ_UP 1
`define LSR_B_IRQ_DOWN 2
`define LSR_IRQ_W 3
`define LSR_IRQ_RST 3'h0
// strap settle time in cycles after reset release
`define LSR_STRAP_WAIT 2'h3
`endif

// ==== core/lsr_pkg.sv ====
// types shared by the link status bank modules
package lsr_pkg;
  // targets of the sideband default loader
  typedef enum logic [1:0] {
    LOAD_CLK = 2'b01,
    LOAD_SLOT = 2'b10
  } load_sel_t;
  // slot presence bits held for software
  typedef struct packed {
    logic attn_ind;
    logic pwr_ctl;
    logic attn_btn;
  } slot_caps_t;
endpackage

// ==== core/lsr_if.sv ====
// signals between the bank and its flag and strap helpers
`timescale 1ns/100ps
interface lsr_if;
  logic train_err_evt; // training error seen, pulse
  logic train_ok_evt; // reached L0 after training, pulse
  logic training_in; // training in progress, level
  logic dl_active_in; // link layer in DL_Active, level
  logic [5:0] width_in; // negotiated lane count
  logic train_err; // sticky training error flag
  logic training; // registered training flag
  logic dl_active; // registered link active flag
  logic [5:0] width; // registered lane count
  logic up_evt; // link active rose, pulse
  logic down_evt; // link active fell, pulse
  logic [1:0] strap_raw; // strap pins, asynchronous
  logic [1:0] strap_val; // strap pins, synchronised
  logic strap_ok; // strap levels have settled
  modport bank (
    output train_err_evt, train_ok_evt, training_in, dl_active_in,
    output width_in, strap_raw,
    input train_err, training, dl_active, width, up_evt, down_evt,
    input strap_val, strap_ok
  );
  modport flags (
    input train_err_evt, train_ok_evt, training_in, dl_active_in,
    input width_in,
    output train_err, training, dl_active, width, up_evt, down_evt
  );
  modport strap (
    input strap_raw,
    output strap_val, strap_ok
  );
endinterface

// ==== core/link_flags.sv ====
// link training and data link flags fed by the link layers
`timescale 1ns/100ps
`include "lsr_consts.svh"
module link_flags (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link layer side
  lsr_if.flags fi
);
  // error flag: an error in the same cycle as L0 entry wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fi.train_err <= 1'b0;
    end else if (fi.train_err_evt) begin
      fi.train_err <= 1'b1;
    end else if (fi.train_ok_evt) begin
      fi.train_err <= 1'b0;
    end
  end
  // training, link active and width follow the layers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fi.training <= 1'b0;
      fi.dl_active <= 1'b0;
      fi.width <= `LSR_WIDTH_RST;
    end else begin
      fi.training <= fi.training_in;
      fi.dl_active <= fi.dl_active_in;
      fi.width <= fi.width_in;
    end
  end
  // edge pulses of the link active state for interrupts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fi.up_evt <= 1'b0;
      fi.down_evt <= 1'b0;
    end else begin
      fi.up_evt <= fi.dl_active_in & ~fi.dl_active;
      fi.down_evt <= ~fi.dl_active_in & fi.dl_active;
    end
  end
  AST_TERR_SET: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fi.train_err_evt |=> fi.train_err)
    else $error("training error flag not set");
  AST_TERR_CLR: assert property (
    @(posedge hclk) disable iff (!hresetn)
    fi.train_ok_evt && !fi.train_err_evt |=> !fi.train_err)
    else $error("training error flag not cleared at L0");
  AST_TRAIN_DONE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(fi.training_in) |=> !fi.training)
    else $error("training flag held after completion");
  // both levels tracked; the release edge itself still sees reset
  AST_DLA: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn |=> fi.dl_active == $past(fi.dl_active_in))
    else $error("link active bit does not follow DL_Active");
endmodule

// ==== core/strap_sync.sv ====
// two-flop synchronisers and settle timer for strap pins
`timescale 1ns/100ps
`include "lsr_consts.svh"
module strap_sync (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // strap pins in, settled levels out
  lsr_if.strap si
);
  logic [1:0] meta; // first stage, read only by the second
  logic [1:0] wait_cnt; // cycles since reset release
  // one synchroniser per strap pin
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta[g] <= 1'b0;
          si.strap_val[g] <= 1'b0;
        end else begin
          meta[g] <= si.strap_raw[g];
          si.strap_val[g] <= meta[g];
        end
      end
    end
  endgenerate
  // the pipe holds reset zeros at first, so wait for it to fill
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt <= 2'h0;
      si.strap_ok <= 1'b0;
    end else if (wait_cnt != `LSR_STRAP_WAIT) begin
      wait_cnt <= wait_cnt + 2'h1;
    end else begin
      si.strap_ok <= 1'b1;
    end
  end
endmodule

// ==== core/pcie_link_status_slot_caps.sv ====
// link status and slot capability bank on an AHB-Lite slave
`timescale 1ns/100ps
`include "lsr_consts.svh"
module pcie_link_status_slot_caps (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // physical and data link layer status
  input wire logic phy_train_err,
  input wire logic phy_train_ok,
  input wire logic phy_training,
  input wire logic [5:0] phy_width,
  input wire logic dll_active,
  // strap pins
  input wire logic strap_slot_clk,
  input wire logic strap_downstream,
  // sideband default loader (smbus or eeprom)
  input wire logic load_valid,
  input wire logic [1:0] load_sel,
  input wire logic [3:0] load_data,
  // interrupt
  output logic irq
);
  // helper links
  lsr_if li ();

  // bus state
  logic acc; // address phase taken this cycle
  logic [11:0] acc_addr; // low address bits
  logic wr_pend; // write data phase follows
  logic [11:0] wr_addr; // address of that write
  logic [31:0] next_rdata; // read data for the data phase

  // held configuration
  logic slot_clk; // slot clock configuration bit
  logic downstream; // port is downstream
  logic strap_taken; // straps have been captured
  lsr_pkg::slot_caps_t caps; // slot presence bits

  // interrupt state
  logic [`LSR_IRQ_W-1:0] irq_stat; // sticky events
  logic [`LSR_IRQ_W-1:0] irq_mask; // enables
  logic [`LSR_IRQ_W-1:0] irq_set; // events this cycle
  logic [`LSR_IRQ_W-1:0] irq_clr; // cleared by a read
  logic stat_rd; // status read taken

  // words as software sees them
  logic [31:0] link_word;
  logic [31:0] slot_word;

  // wire the layer inputs to the flag helper
  assign li.train_err_evt = phy_train_err;
  assign li.train_ok_evt = phy_train_ok;
  assign li.training_in = phy_training;
  assign li.dl_active_in = dll_active;
  assign li.width_in = phy_width;
  assign li.strap_raw = {strap_downstream, strap_slot_clk};

  // training and link flags
  link_flags u_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .fi(li.flags)
  );

  // strap synchronisers
  strap_sync u_strap (
    .hclk(hclk),
    .hresetn(hresetn),
    .si(li.strap)
  );

  // a transfer is taken when selected, non-idle and bus ready
  assign acc = hsel & htrans[1] & hready;
  assign acc_addr = haddr[11:0];

  // status word: link control half is not part of this bank
  always_comb begin
    link_word = 32'h0000_0000;
    link_word[`LSR_B_SPEED +: 4] = `LSR_SPEED_CODE;
    link_word[`LSR_B_WIDTH +: 6] = li.width;
    link_word[`LSR_B_TERR] = li.train_err;
    link_word[`LSR_B_TRAIN] = li.training;
    link_word[`LSR_B_SCLK] = slot_clk;
    link_word[`LSR_B_DLA] = li.dl_active;
    link_word[`LSR_B_RSVD +: 2] = 2'h0;
  end

  // slot word: remaining capability fields read as zero
  always_comb begin
    slot_word = 32'h0000_0000;
    slot_word[`LSR_B_ABP] = caps.attn_btn;
    slot_word[`LSR_B_PCP] = caps.pwr_ctl;
    slot_word[`LSR_B_AIP] = caps.attn_ind;
  end

  // read mux; unmapped or absent addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (acc_addr == `LSR_OFS_LINK) begin
      next_rdata = link_word;
    end else if (acc_addr == `LSR_OFS_SLOT) begin
      // the capability word exists on downstream ports only
      if (downstream) begin
        next_rdata = slot_word;
      end
    end else if (acc_addr == `LSR_OFS_IRQ_STAT) begin
      next_rdata[`LSR_IRQ_W-1:0] = irq_stat;
    end else if (acc_addr == `LSR_OFS_IRQ_MASK) begin
      next_rdata[`LSR_IRQ_W-1:0] = irq_mask;
    end
  end

  // zero wait states: ready and okay stand from reset on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // the master never sees a wait state or an error response
  AST_READY: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("slave not ready or response not okay");

  // read data is latched at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // read data stands until the next read is taken
  AST_RDATA_HOLD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn && !(acc && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  // remember writes so their data phase can be decoded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else if (hready) begin
      wr_pend <= acc & hwrite;
      wr_addr <= acc_addr;
    end
  end

  // straps land once settled, loader writes override the slot clock later
  // a load in the capture cycle wins so it is never lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_clk <= 1'b0;
      downstream <= 1'b0;
      strap_taken <= 1'b0;
    end else begin
      if (!strap_taken && li.strap_ok) begin
        strap_taken <= 1'b1;
        slot_clk <= li.strap_val[0];
        downstream <= li.strap_val[1];
      end
      if (load_valid && load_sel == lsr_pkg::LOAD_CLK) begin
        slot_clk <= load_data[0];
      end
    end
  end

  // the strap level lands once, unless a load wins that cycle
  AST_STRAP_TAKE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !strap_taken && li.strap_ok
    && !(load_valid && load_sel == lsr_pkg::LOAD_CLK)
    |=> slot_clk == $past(li.strap_val[0]))
    else $error("slot clock strap not captured");

  // slot presence bits change only through the loader;
  // bus writes to the capability word are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      caps <= '0;
    end else if (load_valid && load_sel == lsr_pkg::LOAD_SLOT) begin
      caps.attn_btn <= load_data[`LSR_B_ABP];
      caps.pwr_ctl <= load_data[`LSR_B_PCP];
      caps.attn_ind <= load_data[`LSR_B_AIP];
    end
  end

  // a downstream read of the capability word shows the held bits
  AST_SLOT_RD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && acc_addr == `LSR_OFS_SLOT && downstream
    |=> hrdata == {28'h0000000, $past(caps.attn_ind), 1'b0,
      $past(caps.pwr_ctl), $past(caps.attn_btn)})
    else $error("slot presence bits not returned");

  // mask is the only writable word; status fields ignore writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask <= `LSR_IRQ_RST;
    end else if (wr_pend && wr_addr == `LSR_OFS_IRQ_MASK) begin
      irq_mask <= hwdata[`LSR_IRQ_W-1:0];
    end
  end

  // a mask write lands with its data phase
  AST_MASK_WR: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_addr == `LSR_OFS_IRQ_MASK
    |=> irq_mask == $past(hwdata[`LSR_IRQ_W-1:0]))
    else $error("mask write not applied");

  // events from the layers
  always_comb begin
    irq_set = '0;
    irq_set[`LSR_B_IRQ_TERR] = phy_train_err;
    irq_set[`LSR_B_IRQ_UP] = li.up_evt;
    irq_set[`LSR_B_IRQ_DOWN] = li.down_evt;
  end
  assign stat_rd = acc && !hwrite && acc_addr == `LSR_OFS_IRQ_STAT;
  assign irq_clr = stat_rd ? irq_stat : '0;

  // read clears only what was returned; a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= `LSR_IRQ_RST;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  // a status read clears what it returned; link edges are kept
  AST_STAT_CLR: assert property (
    @(posedge hclk) disable iff (!hresetn)
    stat_rd && !phy_train_err |=> !irq_stat[`LSR_B_IRQ_TERR])
    else $error("status read did not clear the error event");
  AST_UP_STAT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    li.up_evt |=> irq_stat[`LSR_B_IRQ_UP])
    else $error("link up event lost in status");
  AST_DOWN_STAT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    li.down_evt |=> irq_stat[`LSR_B_IRQ_DOWN])
    else $error("link down event lost in status");

  // level interrupt, one cycle behind the status word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // the release edge still sees reset, so start one edge later
  AST_IRQ_LVL: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hresetn |=> irq == |($past(irq_stat) & $past(irq_mask)))
    else $error("interrupt level does not follow status and mask");

  // each field of a link read but training against its source, then slot, loader, training and status checks
  AST_SPEED: assert property (
    @(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && acc_addr == `LSR_OFS_LINK
    |=> hrdata[`LSR_B_SPEED +: 4] == `LSR_SPEED_CODE)
    else $error("link speed code wrong");
  AST_RSVD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && acc_addr == `LSR_OFS_LINK
    |=> hrdata[`LSR_B_RSVD +: 2] == 2'h0)
    else $error("reserved link status bits not zero");
  AST_LOW_HALF: assert property (
    @(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && acc_addr == `LSR_OFS_LINK
    |=> hrdata[15:0] == 16'h0000)
    else $error("link control half not zero");
  AST_WIDTH: assert property (
    @(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && acc_addr == `LSR_OFS_LINK
    |=> hrdata[`LSR_B_WIDTH +: 6] == $past(li.width))
    else $error("negotiated width not returned");
  AST_TERR_RD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && acc_addr == `LSR_OFS_LINK
    |=> hrdata[`LSR_B_TERR] == $past(li.train_err))
    else $error("training error flag not reported");
  AST_SCLK_RD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && acc_addr == `LSR_OFS_LINK
    |=> hrdata[`LSR_B_SCLK] == $past(slot_clk))
    else $error("slot clock bit not reported");
  AST_DLA_RD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && acc_addr == `LSR_OFS_LINK
    |=> hrdata[`LSR_B_DLA] == $past(li.dl_active))
    else $error("link active bit not reported");
  AST_SLOT_ABSENT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    acc && !hwrite && acc_addr == `LSR_OFS_SLOT && !downstream
    |=> hrdata == 32'h0000_0000)
    else $error("slot word visible on upstream port");
  AST_SCLK_LOAD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    load_valid && load_sel == lsr_pkg::LOAD_CLK
    |=> slot_clk == $past(load_data[0]))
    else $error("slot clock load not applied");
  AST_CAPS_RO: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !load_valid |=> $stable(caps))
    else $error("slot presence bits changed without a load");
  AST_TRAIN_RD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    phy_training ##1 acc && !hwrite && acc_addr == `LSR_OFS_LINK
    |=> hrdata[`LSR_B_TRAIN])
    else $error("training flag not reported");
  AST_STAT_SET: assert property (
    @(posedge hclk) disable iff (!hresetn)
    phy_train_err |=> irq_stat[`LSR_B_IRQ_TERR] ##1 1'b1)
    else $error("error event lost in status");
endmodule

// ==== verif/link_layer_model.sv ====
// behavioural model of the physical and data link layers
`timescale 1ns/100ps
module link_layer_model (
  // clock
  input wire logic hclk,
  // layer status towards the bank
  output logic phy_train_err,
  output logic phy_train_ok,
  output logic phy_training,
  output logic [5:0] phy_width,
  output logic dll_active
);
  // idle link at time zero: not training, one lane, link layer down
  initial begin
    phy_train_err = 1'b0;
    phy_train_ok = 1'b0;
    phy_training = 1'b0;
    phy_width = 6'h01;
    dll_active = 1'b0;
  end

  // training runs for a chosen number of cycles, short or long
  task automatic train_begin(input int hold);
    phy_training <= 1'b1;
    repeat (hold + 2) @(posedge hclk);
  endtask

  // training ends with a one-cycle success or error pulse
  task automatic train_end(input logic ok, input logic [5:0] w);
    phy_training <= 1'b0;
    phy_width <= w;
    phy_train_ok <= ok;
    phy_train_err <= ~ok;
    @(posedge hclk);
    phy_train_ok <= 1'b0;
    phy_train_err <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  // link layer state is a level, changed only after an edge
  task automatic set_active(input logic a);
    dll_active <= a;
    repeat (3) @(posedge hclk);
  endtask
endmodule

// ==== verif/pcie_link_status_slot_caps_test.sv ====
// self-checking bench for the link status and slot capability bank
`timescale 1ns/100ps
`include "lsr_consts.svh"
module pcie_link_status_slot_caps_test;
  // clock, reset and bus master
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  // layer status from the model
  logic phy_train_err;
  logic phy_train_ok;
  logic phy_training;
  logic [5:0] phy_width;
  logic dll_active;
  // straps, loader and interrupt
  logic strap_slot_clk;
  logic strap_downstream;
  logic load_valid;
  logic [1:0] load_sel;
  logic [3:0] load_data;
  logic irq;
  int fail_count;
  int checks_done;
  logic [31:0] rdat; // word taken by the last transfer
  logic rsp; // response taken with the last transfer
  logic [3:0] caps [4] = '{4'h1, 4'h2, 4'h8, 4'hB}; // one bit, then all

  // 25 MHz clock
  always #20 hclk = ~hclk;

  pcie_link_status_slot_caps u_pcie_link_status_slot_caps (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .phy_train_err(phy_train_err),
    .phy_train_ok(phy_train_ok), .phy_training(phy_training),
    .phy_width(phy_width), .dll_active(dll_active),
    .strap_slot_clk(strap_slot_clk), .strap_downstream(strap_downstream),
    .load_valid(load_valid), .load_sel(load_sel), .load_data(load_data),
    .irq(irq)
  );

  link_layer_model u_link_layer_model (
    .hclk(hclk), .phy_train_err(phy_train_err),
    .phy_train_ok(phy_train_ok), .phy_training(phy_training),
    .phy_width(phy_width), .dll_active(dll_active)
  );

  // expected link status word; the low half always reads zero
  function automatic logic [31:0] link_word(input logic trn,
      input logic err, input logic clk, input logic dla,
      input logic [5:0] w);
    return {2'b00, dla, clk, trn, err, w, 4'h1, 16'h0000};
  endfunction

  // the one place where the run ends
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask

  task automatic tdone(input string nm);
    $display("test %s done", nm);
  endtask

  // bounded wait for hready; a hung slave ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      summarize();
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rdat = hrdata;
    rsp = hresp;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
      input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(nm, rdat, exp);
    check("hresp", {31'h0, rsp}, 32'h00000000);
  endtask

  // sideband load pulse; the field lands one edge after the strobe
  task automatic load(input logic [1:0] sel, input logic [3:0] d);
    load_valid <= 1'b1;
    load_sel <= sel;
    load_data <= d;
    @(posedge hclk);
    load_valid <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask

  // irq is registered, so give it a few edges to settle
  task automatic irqchk(input logic exp);
    repeat (3) @(posedge hclk);
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  // straps settle some edges after release, so wait well past that
  task automatic reset_dut();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (10) @(posedge hclk);
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    strap_slot_clk = 1'b1;
    strap_downstream = 1'b1;
    load_valid = 1'b0;
    load_sel = 2'h0;
    load_data = 4'h0;
    fail_count = 0;
    checks_done = 0;
    @(posedge hclk);
    reset_dut();
    // reset contents with the slot clock strap high
    rdchk("link", `LSR_OFS_LINK, link_word(0, 0, 1, 0, 6'h01));
    rdchk("slot", `LSR_OFS_SLOT, 32'h00000000);
    rdchk("stat", `LSR_OFS_IRQ_STAT, 32'h00000000);
    rdchk("mask", `LSR_OFS_IRQ_MASK, 32'h00000000);
    tdone("reset");
    // sideband loader overrides, then software writes are dropped
    load(2'b01, 4'h0);
    rdchk("link", `LSR_OFS_LINK, link_word(0, 0, 0, 0, 6'h01));
    foreach (caps[i]) begin
      load(2'b10, caps[i]);
      rdchk("slot", `LSR_OFS_SLOT, {28'h0000000, caps[i]});
    end
    wr(`LSR_OFS_LINK, 32'hFFFFFFFF);
    wr(`LSR_OFS_SLOT, 32'h00000000);
    rdchk("link", `LSR_OFS_LINK, link_word(0, 0, 0, 0, 6'h01));
    rdchk("slot", `LSR_OFS_SLOT, 32'h0000000B);
    rdchk("unmapped", 12'h200, 32'h00000000);
    tdone("loader");
    // training ends in error while the interrupt is masked
    u_link_layer_model.train_begin(2);
    rdchk("link", `LSR_OFS_LINK, link_word(1, 0, 0, 0, 6'h01));
    u_link_layer_model.train_end(1'b0, 6'h04);
    wr(`LSR_OFS_LINK, 32'h00000000);
    rdchk("link", `LSR_OFS_LINK, link_word(0, 1, 0, 0, 6'h04));
    irqchk(1'b0);
    rdchk("stat", `LSR_OFS_IRQ_STAT, 32'h00000001);
    rdchk("stat", `LSR_OFS_IRQ_STAT, 32'h00000000);
    tdone("train error");
    // unmasked error raises irq, read of status drops it
    wr(`LSR_OFS_IRQ_MASK, 32'h00000007);
    rdchk("mask", `LSR_OFS_IRQ_MASK, 32'h00000007);
    u_link_layer_model.train_begin(0);
    u_link_layer_model.train_end(1'b0, 6'h04);
    irqchk(1'b1);
    rdchk("stat", `LSR_OFS_IRQ_STAT, 32'h00000001);
    irqchk(1'b0);
    // long retrain that reaches L0 clears the error flag
    u_link_layer_model.train_begin(20);
    u_link_layer_model.train_end(1'b1, 6'h02);
    rdchk("link", `LSR_OFS_LINK, link_word(0, 0, 0, 0, 6'h02));
    tdone("interrupt");
    // link layer up and down, both edges reported
    u_link_layer_model.set_active(1'b1);
    rdchk("link", `LSR_OFS_LINK, link_word(0, 0, 0, 1, 6'h02));
    irqchk(1'b1);
    rdchk("stat", `LSR_OFS_IRQ_STAT, 32'h00000002);
    u_link_layer_model.set_active(1'b0);
    rdchk("link", `LSR_OFS_LINK, link_word(0, 0, 0, 0, 6'h02));
    rdchk("stat", `LSR_OFS_IRQ_STAT, 32'h00000004);
    wr(`LSR_OFS_IRQ_MASK, 32'h00000000);
    u_link_layer_model.set_active(1'b1);
    irqchk(1'b0);
    rdchk("stat", `LSR_OFS_IRQ_STAT, 32'h00000002);
    tdone("link active");
    // mid-run reset as an upstream port: the slot word reads zero
    load(2'b10, 4'hB);
    strap_downstream <= 1'b0;
    strap_slot_clk <= 1'b0;
    reset_dut();
    rdchk("slot", `LSR_OFS_SLOT, 32'h00000000);
    rdchk("link", `LSR_OFS_LINK, link_word(0, 0, 0, 1, 6'h02));
    tdone("upstream");
    summarize();
  end
endmodule
